// *** core/digipot_pair.sv ***
// two-channel digital potentiometer with AHB-Lite register slave
`timescale 1ns/10ps
`include "digipot_regs.svh"
module digipot_pair
  import digipot_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // supervisory state machine and reference routing, asynchronous pins
  input wire logic ready_to_operating,
  input wire logic ch1_select,
  input wire logic ch2_select,
  input wire logic [15:0] ch1_prev_ref,
  input wire logic [15:0] ch2_prev_ref,
  input wire logic [15:0] ch1_ref,
  input wire logic [15:0] ch2_ref,
  // outputs
  output logic [15:0] ch1_value,
  output logic [15:0] ch2_value,
  output logic irq
);
  localparam int NREG = 8;

  typedef struct packed {
    logic wpend;
    logic [11:0] waddr;
    logic [31:0] rdata;
    logic [15:0] command;
    logic [1:0] control1;
    logic [1:0] control2;
    logic [3:0] irq_status;
    logic [3:0] irq_mask;
    logic [NREG-1:0][15:0] cfg1;
    logic [NREG-1:0][15:0] cfg2;
    logic [1:0] rto_sync;
    logic rto_prev;
    logic [1:0][1:0] sel_sync;
    logic [1:0] sel_prev;
    logic [1:0] ramp_prev;
    logic [15:0] out1;
    logic [15:0] out2;
  } top_state_t;

  top_state_t s;
  top_state_t next_s;
  value_t v1;
  value_t v2;
  logic ramp1;
  logic ramp2;
  logic up1;
  logic up2;
  logic lo1;
  logic lo2;
  logic ev1;
  logic ev2;
  logic load_start;
  logic [1:0] preload;
  logic [15:0] status;
  logic [3:0] events;
  logic [15:0] prev1_q;
  logic [15:0] prev1_s;
  logic [15:0] prev2_q;
  logic [15:0] prev2_s;

  // config register index within a channel window
  function automatic logic [2:0] cfg_index(logic [11:0] a);
    cfg_index = a[4:2];
  endfunction

  // which channel window, 0 for none
  function automatic logic [1:0] cfg_chan(logic [11:0] a);
    if (a >= `OFF_CH_BASE && a < `OFF_CH_BASE + `CH_STRIDE)
      cfg_chan = 2'h1;
    else if (a >= `OFF_CH_BASE + `CH_STRIDE && a < `OFF_CH_BASE + 12'h040)
      cfg_chan = 2'h2;
    else
      cfg_chan = 2'h0;
  endfunction

  // status flags of one channel
  function automatic logic [5:0] flags(logic en, logic rmp, logic hi, logic lo, logic trk,
                                       logic eq);
    flags = {eq, trk, lo, hi, rmp, en};
  endfunction

  // previous-reference bus is multi-bit: sampled twice, used only at select edges
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      prev1_q <= 16'h0000;
      prev1_s <= 16'h0000;
      prev2_q <= 16'h0000;
      prev2_s <= 16'h0000;
    end
    else
    begin
      prev1_q <= ch1_prev_ref;
      prev1_s <= prev1_q;
      prev2_q <= ch2_prev_ref;
      prev2_s <= prev2_q;
    end
  end

  assign load_start = s.rto_sync[1] && !s.rto_prev;
  // tracking: rising select while tracking enabled takes prior reference
  assign preload[0] = s.control1[`CTL_TRACK] && s.sel_sync[0][1] && !s.sel_prev[0];
  assign preload[1] = s.control2[`CTL_TRACK] && s.sel_sync[1][1] && !s.sel_prev[1];

  assign status = {2'b00,
                   flags(s.control2[`CTL_ENABLE], ramp2, up2, lo2, s.control2[`CTL_TRACK],
                         s.out2 == ch2_ref),
                   2'b00,
                   flags(s.control1[`CTL_ENABLE], ramp1, up1, lo1, s.control1[`CTL_TRACK],
                         s.out1 == ch1_ref)};
  // events: step 1, step 2, ramp start 1, ramp start 2
  assign events = {ramp2 && !s.ramp_prev[1], ramp1 && !s.ramp_prev[0], ev2, ev1};

  always_comb
  begin
    next_s = s;
    next_s.rto_sync = {s.rto_sync[0], ready_to_operating};
    next_s.rto_prev = s.rto_sync[1];
    next_s.sel_sync[0] = {s.sel_sync[0][0], ch1_select};
    next_s.sel_sync[1] = {s.sel_sync[1][0], ch2_select};
    next_s.sel_prev = {s.sel_sync[1][1], s.sel_sync[0][1]};
    next_s.ramp_prev = {ramp2, ramp1};
    next_s.out1 = v1;
    next_s.out2 = v2;
    next_s.wpend = 1'b0;
    // write data phase
    if (s.wpend)
    begin
      if (s.waddr == `OFF_COMMAND)
        next_s.command = hwdata[15:0] & 16'h0707;
      else if (s.waddr == `OFF_IRQ_STATUS)
        next_s.irq_status = s.irq_status & ~hwdata[3:0];
      else if (s.waddr == `OFF_IRQ_MASK)
        next_s.irq_mask = hwdata[3:0];
      else if (s.waddr == `OFF_CONTROL)
      begin
        next_s.control1 = hwdata[1:0];
        next_s.control2 = hwdata[9:8];
      end
      else if (cfg_chan(s.waddr) == 2'h1 && cfg_index(s.waddr) != 3'h7)
        next_s.cfg1[cfg_index(s.waddr)] = hwdata[15:0];
      else if (cfg_chan(s.waddr) == 2'h2 && cfg_index(s.waddr) != 3'h7)
        next_s.cfg2[cfg_index(s.waddr)] = hwdata[15:0];
    end
    // set wins over a simultaneous clear
    next_s.irq_status = next_s.irq_status | events;
    // address phase
    if (hsel && hready && htrans[1])
    begin
      next_s.wpend = hwrite;
      next_s.waddr = haddr;
      next_s.rdata = 32'h0000_0000;
      if (!hwrite)
      begin
        if (haddr == `OFF_STATUS)
          next_s.rdata = {16'h0000, status};
        else if (haddr == `OFF_COMMAND)
          next_s.rdata = {16'h0000, s.command};
        else if (haddr == `OFF_IRQ_STATUS)
          next_s.rdata = {28'h0000000, s.irq_status};
        else if (haddr == `OFF_IRQ_MASK)
          next_s.rdata = {28'h0000000, s.irq_mask};
        else if (haddr == `OFF_CONTROL)
          next_s.rdata = {22'h000000, s.control2, 6'h00, s.control1};
        else if (cfg_chan(haddr) == 2'h1)
          next_s.rdata = {16'h0000, cfg_index(haddr) == 3'h7 ? s.out1 :
                          s.cfg1[cfg_index(haddr)]};
        else if (cfg_chan(haddr) == 2'h2)
          next_s.rdata = {16'h0000, cfg_index(haddr) == 3'h7 ? s.out2 :
                          s.cfg2[cfg_index(haddr)]};
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s <= '0;
      s.control1 <= 2'b01;
      s.control2 <= 2'b01;
      for (int i = 0; i < 2; i++)
      begin
        s.cfg1[i] <= `RST_STEP;
        s.cfg2[i] <= `RST_STEP;
      end
      s.cfg1[2] <= `RST_UPPER;
      s.cfg2[2] <= `RST_UPPER;
      s.cfg1[3] <= `RST_LOWER;
      s.cfg2[3] <= `RST_LOWER;
      s.cfg1[5] <= `RST_RAMP_DELAY;
      s.cfg2[5] <= `RST_RAMP_DELAY;
      s.cfg1[6] <= `RST_RAMP_DIV;
      s.cfg2[6] <= `RST_RAMP_DIV;
    end
    else
      s <= next_s;
  end

  // two independent channels
  pot_channel u_ch1 (
    .hclk(hclk), .hresetn(hresetn),
    .enable(s.control1[`CTL_ENABLE]),
    .cmd_up(s.command[`CW_UP]), .cmd_down(s.command[`CW_DOWN]),
    .cmd_clear(s.command[`CW_CLEAR]),
    .load_start(load_start), .preload(preload[0]), .preload_value(prev1_s),
    .step_up(s.cfg1[0]), .step_down(s.cfg1[1]), .upper(s.cfg1[2]), .lower(s.cfg1[3]),
    .start(s.cfg1[4]), .ramp_delay(s.cfg1[5]), .ramp_div(s.cfg1[6]),
    .value(v1), .ramp_active(ramp1), .at_upper(up1), .at_lower(lo1), .step_event(ev1)
  );

  pot_channel u_ch2 (
    .hclk(hclk), .hresetn(hresetn),
    .enable(s.control2[`CTL_ENABLE]),
    .cmd_up(s.command[`CW_UP + `CH2_SHIFT]), .cmd_down(s.command[`CW_DOWN + `CH2_SHIFT]),
    .cmd_clear(s.command[`CW_CLEAR + `CH2_SHIFT]),
    .load_start(load_start), .preload(preload[1]), .preload_value(prev2_s),
    .step_up(s.cfg2[0]), .step_down(s.cfg2[1]), .upper(s.cfg2[2]), .lower(s.cfg2[3]),
    .start(s.cfg2[4]), .ramp_delay(s.cfg2[5]), .ramp_div(s.cfg2[6]),
    .value(v2), .ramp_active(ramp2), .at_upper(up2), .at_lower(lo2), .step_event(ev2)
  );

  assign ch1_value = s.out1;
  assign ch2_value = s.out2;
  assign hrdata = s.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign irq = |(s.irq_status & s.irq_mask);

  chk_status_ramp: assert property (@(posedge hclk) disable iff (!hresetn)
    status[`ST_RAMP] |-> $past(s.command[`CW_UP]) || $past(s.command[`CW_DOWN]))
    else $error("status ramp bit without held command");
  // channel state leads the output port by one cycle, so compare a cycle later
  chk_limit_flag: assert property (@(posedge hclk) disable iff (!hresetn)
    ##1 ($past(status[`ST_UPPER]) == (s.out1 == $past(s.cfg1[2]))
      && $past(status[`ST_LOWER]) == (s.out1 == $past(s.cfg1[3]))))
    else $error("limit flag does not follow output");
  chk_start_load: assert property (@(posedge hclk) disable iff (!hresetn)
    load_start |-> ##2 ch1_value == $past(s.cfg1[4], 2))
    else $error("start value not loaded");
  chk_status_reserved: assert property (@(posedge hclk) disable iff (!hresetn)
    status[7:6] == 2'b00 && status[15:14] == 2'b00)
    else $error("reserved status bits set");
  chk_irq_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
    events[0] |=> s.irq_status[0])
    else $error("event lost");
  cov_irq: cover property (@(posedge hclk) disable iff (!hresetn) $rose(irq));
  cov_preload: cover property (@(posedge hclk) disable iff (!hresetn) preload[0]);
endmodule

// *** core/digipot_regs.svh ***
// register offsets, field positions, reset values and timing counts of the potentiometer pair
`ifndef DIGIPOT_REGS_SVH
`define DIGIPOT_REGS_SVH

`define OFF_STATUS 12'h000
`define OFF_COMMAND 12'h004
`define OFF_IRQ_STATUS 12'h008
`define OFF_IRQ_MASK 12'h00C
`define OFF_CONTROL 12'h010
`define OFF_CH_BASE 12'h020
`define CH_STRIDE 12'h020
`define CH_STEP_UP 12'h000
`define CH_STEP_DOWN 12'h004
`define CH_UPPER 12'h008
`define CH_LOWER 12'h00C
`define CH_START 12'h010
`define CH_RAMP_DELAY 12'h014
`define CH_RAMP_DIV 12'h018
`define CH_OUTPUT 12'h01C

`define CW_UP 0
`define CW_DOWN 1
`define CW_CLEAR 2
`define CH2_SHIFT 8

`define ST_ENABLED 0
`define ST_RAMP 1
`define ST_UPPER 2
`define ST_LOWER 3
`define ST_TRACK 4
`define ST_EQUAL 5

`define CTL_ENABLE 0
`define CTL_TRACK 1

`define RST_UPPER 16'h7FFF
`define RST_LOWER 16'h8001
`define RST_STEP 16'h0010
`define RST_RAMP_DELAY 16'h0064
`define RST_RAMP_DIV 16'h000A

`endif

// *** core/digipot_pkg.sv ***
// types shared by the potentiometer pair
package digipot_pkg;
  typedef enum logic [1:0] {IDLE, HOLD, RAMP} dir_state_t;
  typedef logic signed [15:0] value_t;
endpackage

// *** core/pot_channel.sv ***
// one step-and-ramp potentiometer channel
`timescale 1ns/10ps
module pot_channel
  import digipot_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // commands
  input wire logic enable,
  input wire logic cmd_up,
  input wire logic cmd_down,
  input wire logic cmd_clear,
  input wire logic load_start,
  input wire logic preload,
  input wire value_t preload_value,
  // configuration
  input wire value_t step_up,
  input wire value_t step_down,
  input wire value_t upper,
  input wire value_t lower,
  input wire value_t start,
  input wire logic [15:0] ramp_delay,
  input wire logic [15:0] ramp_div,
  // results
  output value_t value,
  output logic ramp_active,
  output logic at_upper,
  output logic at_lower,
  output logic step_event
);
  typedef struct packed {
    dir_state_t st;
    logic dir_up;
    logic prev_up;
    logic prev_down;
    logic [15:0] hold_cnt;
    logic [15:0] div_cnt;
    value_t val;
    logic ev;
  } ch_state_t;

  ch_state_t s;
  ch_state_t next_s;

  // saturating move, used for steps and ramp ticks alike
  function automatic value_t move(value_t v, value_t d, logic up, value_t hi, value_t lo);
    logic signed [16:0] t;
    t = up ? 17'(v) + 17'(d) : 17'(v) - 17'(d);
    if (up && t > 17'(hi))
      move = hi;
    else if (!up && t < 17'(lo))
      move = lo;
    else
      move = t[15:0];
  endfunction

  always_comb
  begin
    next_s = s;
    next_s.ev = 1'b0;
    next_s.prev_up = cmd_up;
    next_s.prev_down = cmd_down;
    if (cmd_clear || load_start)
    begin
      next_s.val = start;
      next_s.st = IDLE;
    end
    else if (preload)
      next_s.val = preload_value;
    else if (enable)
    begin
      case (s.st)
        IDLE:
        begin
          // opposite command ignored while one is held
          if (cmd_up && !s.prev_up)
          begin
            next_s.val = move(s.val, step_up, 1'b1, upper, lower);
            next_s.st = HOLD;
            next_s.dir_up = 1'b1;
            next_s.hold_cnt = 16'h0001;
            next_s.ev = 1'b1;
          end
          else if (cmd_down && !s.prev_down)
          begin
            next_s.val = move(s.val, step_down, 1'b0, upper, lower);
            next_s.st = HOLD;
            next_s.dir_up = 1'b0;
            next_s.hold_cnt = 16'h0001;
            next_s.ev = 1'b1;
          end
        end
        HOLD:
        begin
          if (s.dir_up ? !cmd_up : !cmd_down)
            next_s.st = IDLE;
          else if (s.hold_cnt >= ramp_delay)
          begin
            next_s.st = RAMP;
            next_s.div_cnt = 16'h0000;
          end
          else
            next_s.hold_cnt = s.hold_cnt + 16'h0001;
        end
        RAMP:
        begin
          if (s.dir_up ? !cmd_up : !cmd_down)
            next_s.st = IDLE;
          else if (s.div_cnt + 16'h0001 >= ramp_div)
          begin
            // one unit per ramp_div cycles sets the slope
            next_s.div_cnt = 16'h0000;
            next_s.val = move(s.val, 16'h0001, s.dir_up, upper, lower);
          end
          else
            next_s.div_cnt = s.div_cnt + 16'h0001;
        end
        default:
          next_s.st = IDLE;
      endcase
    end
    else
      next_s.st = IDLE;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      s <= '0;
    else
      s <= next_s;
  end

  assign value = s.val;
  assign ramp_active = (s.st == RAMP);
  assign at_upper = (s.val == upper);
  assign at_lower = (s.val == lower);
  assign step_event = s.ev;

  chk_clear_start: assert property (@(posedge hclk) disable iff (!hresetn)
    cmd_clear |=> value == $past(start))
    else $error("clear did not load start value");
  chk_step_up_sat: assert property (@(posedge hclk) disable iff (!hresetn)
    (enable && !cmd_clear && !load_start && !preload && s.st == IDLE && cmd_up && !s.prev_up)
      |=> value >= $past(value) && value <= $past(upper))
    else $error("step up wrong");
  chk_step_down_sat: assert property (@(posedge hclk) disable iff (!hresetn)
    (enable && !cmd_clear && !load_start && !preload && s.st == IDLE && cmd_down
      && !cmd_up && !s.prev_down) |=> value <= $past(value) && value >= $past(lower))
    else $error("step down wrong");
  chk_ramp_needs_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(ramp_active) |-> $past(cmd_up) || $past(cmd_down))
    else $error("ramp began without held command");
  chk_opposite_ignored: assert property (@(posedge hclk) disable iff (!hresetn)
    (s.st == RAMP && s.dir_up && cmd_up && cmd_down && !cmd_clear && !load_start && !preload)
      |=> value >= $past(value))
    else $error("opposite command moved output");
  cov_ramp_up: cover property (@(posedge hclk) disable iff (!hresetn)
    $rose(ramp_active) && s.dir_up);
  cov_ramp_down: cover property (@(posedge hclk) disable iff (!hresetn)
    $rose(ramp_active) && !s.dir_up);
  cov_hit_upper: cover property (@(posedge hclk) disable iff (!hresetn) $rose(at_upper));
endmodule

// *** tb/ref_source.sv ***
// partner model: supervisory state machine and reference routing pins
`timescale 1ns/10ps
module ref_source
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // requests from the bench
  input wire logic op_req,
  input wire logic [1:0] sel_req,
  input wire logic [15:0] ref_val,
  // pins toward the block
  output logic ready_to_operating,
  output logic ch1_select,
  output logic ch2_select,
  output logic [15:0] ch1_prev_ref,
  output logic [15:0] ch2_prev_ref,
  output logic [15:0] ch1_ref,
  output logic [15:0] ch2_ref
);
  logic [1:0] sel_d;
  // previous reference is set a cycle ahead of the switch so the sampler sees it stable
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ready_to_operating <= 1'b0;
      sel_d <= 2'b00;
      ch1_select <= 1'b0;
      ch2_select <= 1'b0;
      ch1_prev_ref <= 16'h0000;
      ch2_prev_ref <= 16'h0000;
    end
    else
    begin
      ready_to_operating <= op_req;
      ch1_prev_ref <= ref_val;
      ch2_prev_ref <= ref_val;
      sel_d <= sel_req;
      ch1_select <= sel_d[0];
      ch2_select <= sel_d[1];
    end
  end
  assign ch1_ref = ch1_prev_ref;
  assign ch2_ref = ch2_prev_ref;
endmodule

// *** tb/digipot_pair_bench.sv ***
// self-checking bench of the potentiometer pair over its register bus
`timescale 1ns/10ps
`include "digipot_regs.svh"
module digipot_pair_bench;
  localparam logic [11:0] C1 = `OFF_CH_BASE;
  localparam logic [11:0] C2 = `OFF_CH_BASE + `CH_STRIDE;
  localparam logic [11:0] CMD = `OFF_COMMAND;
  localparam logic [11:0] RA [7] = '{`OFF_CONTROL, C1 + `CH_STEP_UP, C1 + `CH_STEP_DOWN,
    C1 + `CH_UPPER, C1 + `CH_LOWER, C1 + `CH_RAMP_DELAY, C1 + `CH_RAMP_DIV};
  localparam logic [31:0] RE [7] = '{32'h0000_0101, 32'h0000_0010, 32'h0000_0010,
    32'h0000_7FFF, 32'h0000_8001, 32'h0000_0064, 32'h0000_000A};
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic hready;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic rto, s1, s2, irq;
  logic [15:0] p1, p2, r1, r2, v1, v2, v0;
  logic op_req = 1'b0;
  logic [1:0] sel_req = 2'b00;
  logic [15:0] ref_val = 16'h0000;
  logic [31:0] rd;
  int error_cnt = 0;
  int check_count = 0;
  int cycles = 0;

  assign hready = hreadyout;
  always #5 hclk = ~hclk;

  digipot_pair DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ready_to_operating(rto),
    .ch1_select(s1), .ch2_select(s2), .ch1_prev_ref(p1), .ch2_prev_ref(p2),
    .ch1_ref(r1), .ch2_ref(r2), .ch1_value(v1), .ch2_value(v2), .irq(irq));
  ref_source partner (.hclk(hclk), .hresetn(hresetn), .op_req(op_req), .sel_req(sel_req),
    .ref_val(ref_val), .ready_to_operating(rto), .ch1_select(s1), .ch2_select(s2),
    .ch1_prev_ref(p1), .ch2_prev_ref(p2), .ch1_ref(r1), .ch2_ref(r2));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask

  // single word transfer; the master never assumes a wait count
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    check(n, rd, exp);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask

  task automatic pulse(input logic [31:0] c);
    wr(CMD, c);
    wr(CMD, 32'h0000_0000);
    settle(3);
  endtask

  always @(posedge hclk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      error_cnt++;
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 7; i++)
      rdc("reset value", RA[i], RE[i]);
    rdc("status at reset", `OFF_STATUS, 32'h0000_2121);
    wr(12'h100, 32'hFFFF_FFFF);
    rdc("unmapped", 12'h100, 32'h0000_0000);
    wr(C1 + `CH_OUTPUT, 32'h0000_0055);
    rdc("output read only", C1 + `CH_OUTPUT, 32'h0000_0000);
    check("okay response", {31'h0, hresp}, 32'h0);
    $display("test reset and map done");

    wr(C1 + `CH_UPPER, 32'h0000_0030);
    wr(C1 + `CH_RAMP_DELAY, 32'h0000_0FFF);
    wr(`OFF_IRQ_MASK, 32'h0000_0000);
    wr(`OFF_IRQ_STATUS, 32'h0000_000F);
    for (int i = 1; i <= 4; i++)
    begin
      pulse(32'h0000_0001);
      check("ch1 step up", {16'h0000, v1}, (i < 3) ? 16 * i : 32'h30);
      check("ch2 untouched", {16'h0000, v2}, 32'h0000_0000);
    end
    rdc("status upper", `OFF_STATUS, 32'h0000_2105);
    check("irq masked", {31'h0, irq}, 32'h0);
    wr(`OFF_IRQ_MASK, 32'h0000_0001);
    settle(2);
    check("irq unmasked", {31'h0, irq}, 32'h1);
    wr(`OFF_IRQ_STATUS, 32'h0000_0001);
    settle(2);
    check("irq cleared", {31'h0, irq}, 32'h0);
    rdc("irq status", `OFF_IRQ_STATUS, 32'h0000_0000);
    $display("test step up done");

    wr(C1 + `CH_LOWER, 32'h0000_FFF0);
    wr(C1 + `CH_STEP_DOWN, 32'h0000_0020);
    for (int i = 1; i <= 3; i++)
    begin
      pulse(32'h0000_0002);
      check("ch1 step down", {16'h0000, v1}, (i == 1) ? 32'h10 : 32'hFFF0);
    end
    rdc("status lower", `OFF_STATUS, 32'h0000_2109);
    $display("test step down done");

    wr(C1 + `CH_RAMP_DELAY, 32'h0000_0014);
    wr(C1 + `CH_RAMP_DIV, 32'h0000_0004);
    wr(C1 + `CH_UPPER, 32'h0000_7FFF);
    wr(CMD, 32'h0000_0001);
    settle(40);
    rdc("ramp up flag", `OFF_STATUS, 32'h0000_2103);
    check("ramp flag on", {31'h0, rd[1]}, 32'h1);
    check("ramp up moved", {31'h0, $signed(v1) > 16'sh0000}, 32'h1);
    v0 = v1;
    wr(CMD, 32'h0000_0003);
    settle(10);
    check("opposite ignored", {31'h0, $signed(v1) >= $signed(v0)}, 32'h1);
    wr(CMD, 32'h0000_0000);
    settle(3);
    v0 = v1;
    settle(20);
    check("ramp stopped", {16'h0000, v1}, {16'h0000, v0});
    bus(1'b0, `OFF_STATUS, 32'h0);
    check("ramp flag off", {31'h0, rd[1]}, 32'h0);
    wr(C2 + `CH_RAMP_DELAY, 32'h0000_0014);
    wr(C2 + `CH_RAMP_DIV, 32'h0000_0004);
    wr(CMD, 32'h0000_0200);
    settle(40);
    bus(1'b0, `OFF_STATUS, 32'h0);
    check("ch2 ramp flag", {31'h0, rd[9]}, 32'h1);
    check("ch2 ramp down", {31'h0, $signed(v2) < -16'sd16}, 32'h1);
    check("ch1 held", {16'h0000, v1}, {16'h0000, v0});
    rdc("irq events", `OFF_IRQ_STATUS, 32'h0000_000F);
    wr(CMD, 32'h0000_0000);
    $display("test ramp done");

    wr(C1 + `CH_START, 32'h0000_0123);
    wr(CMD, 32'h0000_0004);
    settle(3);
    check("clear forces start", {16'h0000, v1}, 32'h0000_0123);
    wr(CMD, 32'h0000_0000);
    rdc("output register", C1 + `CH_OUTPUT, 32'h0000_0123);
    wr(C2 + `CH_START, 32'h0000_0456);
    @(posedge hclk);
    op_req <= 1'b1;
    settle(8);
    check("ch2 start load", {16'h0000, v2}, 32'h0000_0456);
    check("ch1 start load", {16'h0000, v1}, 32'h0000_0123);
    $display("test clear and start done");

    wr(`OFF_CONTROL, 32'h0000_0103);
    @(posedge hclk);
    ref_val <= 16'h0777;
    settle(2);
    @(posedge hclk);
    sel_req <= 2'b01;
    settle(8);
    check("tracking preload", {16'h0000, v1}, 32'h0000_0777);
    rdc("status tracking", `OFF_STATUS, 32'h0000_0131);
    $display("test tracking done");
    tally_and_finish();
  end
endmodule
